// ==== shared/rbvc_defs.svh ====
`ifndef RBVC_DEFS_SVH
`define RBVC_DEFS_SVH

// ==========================================================
// Reset sources
`define RBVC_NUM_SRC 9
`define RBVC_SRC_POR 0
`define RBVC_SRC_PIN 1
`define RBVC_SRC_CMP 2
`define RBVC_SRC_SW 3
`define RBVC_SRC_VMON 4
`define RBVC_SRC_WDT 5
`define RBVC_SRC_MCD 6
`define RBVC_SRC_FLASH 7
`define RBVC_SRC_USB 8

// ==========================================================
// Boot selection
`define RBVC_BOOT_SIG_VALUE 8'hA5
`define RBVC_RESET_VECTOR 16'h0000
`define RBVC_BOOT_VECTOR_DEF 16'h9A00

// ==========================================================
// Reset values of outputs and release synchroniser depth
`define RBVC_PORT_LATCH_RST 1'b1
`define RBVC_CLK_SEL_INT 2'h0
`define RBVC_RELEASE_STAGES 2

`endif

// ==== shared/rbvc_pkg.sv ====
package rbvc_pkg;
  // Reset controller state
  typedef enum logic [1:0] {RBVC_IN_RESET, RBVC_RELEASE, RBVC_RUN} rbvc_state_e;
  // Reset cause vector
  typedef logic [8:0] rbvc_cause_t;
endpackage

// ==== src/rbvc_reset_ctrl.sv ====
`timescale 1ns/100ps
`include "rbvc_defs.svh"
// Functional notes
// - Halt core while the reset state is active.
// - Reset module registers to defaults; power-on-only bits keep value.
// - In reset, port latches forced to 1 in open-drain mode.
// - Reset disables all interrupts and timers.
// - RAM contents are never altered by reset.
// - Weak pull-ups enabled during and after reset.
// - POR or supply monitor reset drives reset pin low till exit.
// - On exit, program counter cleared and internal oscillator selected.
// - Watchdog runs on leaving reset.
// - Nine reset requests each enter the reset state.
// - Signature byte 0xA5 below lock byte means bootloader present.
// - Bootloader present: start at bootloader vector after any reset.
// - No bootloader: start at 0x0000 after any reset.
module rbvc_reset_ctrl #(
  parameter int NUM_SRC = `RBVC_NUM_SRC,
  parameter logic [15:0] BOOT_VECTOR = `RBVC_BOOT_VECTOR_DEF
) (
  input wire logic clk_in, // System clock
  input wire logic rstn_in, // Async reset, active low
  input wire logic por_req_in, // Power-on detector request
  input wire logic ext_reset_pin_n_in, // Reset pin level, active low
  input wire logic cmp_req_in, // Comparator reset request
  input wire logic sw_req_in, // Software reset command
  input wire logic vmon_req_in, // Supply monitor request
  input wire logic wdt_req_in, // Watchdog timeout
  input wire logic mcd_req_in, // Missing clock detect
  input wire logic flash_err_req_in, // Flash error
  input wire logic usb_req_in, // USB bus reset
  input wire logic [7:0] boot_sig_in, // Flash signature byte
  output logic core_halt_out, // Core stopped
  output logic sys_reset_out, // Module register reset
  output logic por_reset_out, // Reset for power-on-only bits
  output logic [NUM_SRC-1:0] cause_out, // Latched reset causes
  output logic port_latch_out, // Port output latch value
  output logic port_od_out, // Ports open-drain
  output logic weak_pullup_en_out, // Weak pull-ups enabled
  output logic irq_tmr_disable_out, // Interrupts and timers off
  output logic ram_we_block_out, // Blocks RAM writes (no clearing)
  output logic ext_reset_pin_n_out, // Reset pin driven value
  output logic ext_reset_pin_oe_out, // Reset pin output enable
  output logic pc_clear_out, // Program counter clear
  output logic [15:0] start_addr_out, // First fetch address
  output logic [1:0] clk_sel_out, // System clock source select
  output logic wdt_enable_out, // Watchdog enable at start
  output logic boot_present_out // Bootloader signature valid
);

  // ==========================================================
  // Request gathering
  logic [NUM_SRC-1:0] req;
  logic any_req;
  logic supply_req;
  logic [`RBVC_RELEASE_STAGES-1:0] hold_r;
  rbvc_pkg::rbvc_state_e state_r;
  rbvc_pkg::rbvc_state_e state_nxt;
  logic in_reset;
  logic [15:0] start_addr_r;
  logic [15:0] start_addr_nxt;
  logic [NUM_SRC-1:0] cause_r;
  logic pin_oe_r;

  // Signature decode, used twice
  function automatic logic boot_ok(input logic [7:0] sig);
    boot_ok = (sig == `RBVC_BOOT_SIG_VALUE);
  endfunction

  // Request vector
  always_comb
  begin
    req = '0;
    req[`RBVC_SRC_POR] = por_req_in;
    // Own drive on the pin must not read back as a pin request
    req[`RBVC_SRC_PIN] = ~ext_reset_pin_n_in & ~pin_oe_r;
    req[`RBVC_SRC_CMP] = cmp_req_in;
    req[`RBVC_SRC_SW] = sw_req_in;
    req[`RBVC_SRC_VMON] = vmon_req_in;
    req[`RBVC_SRC_WDT] = wdt_req_in;
    req[`RBVC_SRC_MCD] = mcd_req_in;
    req[`RBVC_SRC_FLASH] = flash_err_req_in;
    req[`RBVC_SRC_USB] = usb_req_in;
  end

  assign any_req = |req;
  assign supply_req = por_req_in | vmon_req_in;

  // ==========================================================
  // Release synchroniser: all requests must be gone first
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      hold_r <= '1;
    else if (any_req)
      hold_r <= '1;
    else
      hold_r <= {hold_r[`RBVC_RELEASE_STAGES-2:0], 1'b0};
  end

  // State sequencing
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      rbvc_pkg::RBVC_IN_RESET:
        if (!hold_r[`RBVC_RELEASE_STAGES-1] && !any_req)
          state_nxt = rbvc_pkg::RBVC_RELEASE;
      rbvc_pkg::RBVC_RELEASE:
        state_nxt = any_req ? rbvc_pkg::RBVC_IN_RESET : rbvc_pkg::RBVC_RUN;
      rbvc_pkg::RBVC_RUN:
        if (any_req)
          state_nxt = rbvc_pkg::RBVC_IN_RESET;
      default:
        state_nxt = rbvc_pkg::RBVC_IN_RESET; // Unused code falls to reset
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      state_r <= rbvc_pkg::RBVC_IN_RESET;
    else
      state_r <= state_nxt;
  end

  assign in_reset = (state_r == rbvc_pkg::RBVC_IN_RESET);

  // ==========================================================
  // Reset cause capture: power-on or a request outside reset replaces it, requests in reset add to it
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      cause_r <= '0;
    else if (por_req_in)
      cause_r <= req;
    else if (any_req && !in_reset)
      cause_r <= req;
    else if (in_reset)
      cause_r <= cause_r | req;
  end

  // Reset pin drive for supply-type resets
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      pin_oe_r <= 1'b1;
    else if (supply_req)
      pin_oe_r <= 1'b1;
    else if (state_nxt != rbvc_pkg::RBVC_IN_RESET)
      pin_oe_r <= 1'b0;
  end

  // Start address latched while in reset
  always_comb
  begin
    start_addr_nxt = start_addr_r;
    if (in_reset)
    begin
      if (boot_ok(boot_sig_in))
        start_addr_nxt = BOOT_VECTOR;
      else
        start_addr_nxt = `RBVC_RESET_VECTOR;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      start_addr_r <= `RBVC_RESET_VECTOR;
    else
      start_addr_r <= start_addr_nxt;
  end

  // ==========================================================
  // Outputs
  assign core_halt_out = (state_r != rbvc_pkg::RBVC_RUN);
  assign sys_reset_out = in_reset;
  assign por_reset_out = cause_r[`RBVC_SRC_POR] & in_reset;
  assign cause_out = cause_r;
  assign port_latch_out = `RBVC_PORT_LATCH_RST;
  assign port_od_out = in_reset;
  assign weak_pullup_en_out = 1'b1;
  assign irq_tmr_disable_out = in_reset;
  assign ram_we_block_out = core_halt_out;
  assign ext_reset_pin_n_out = 1'b0;
  assign ext_reset_pin_oe_out = pin_oe_r;
  assign pc_clear_out = core_halt_out;
  assign start_addr_out = start_addr_r;
  assign clk_sel_out = `RBVC_CLK_SEL_INT;
  assign wdt_enable_out = 1'b1;
  assign boot_present_out = boot_ok(boot_sig_in);

  // ==========================================================
  // Checks
  property p_halt_on_req;
    @(posedge clk_in) disable iff (!rstn_in)
    any_req |=> core_halt_out;
  endproperty
  a_halt_on_req: assert property (p_halt_on_req)
    else $error("core ran with reset request pending");

  property p_release_delay;
    @(posedge clk_in) disable iff (!rstn_in)
    $fell(core_halt_out) |-> $past(!any_req, 1) && $past(!any_req, 2);
  endproperty
  a_release_delay: assert property (p_release_delay)
    else $error("reset released too early");

  property p_pin_drive;
    @(posedge clk_in) disable iff (!rstn_in)
    supply_req |=> ext_reset_pin_oe_out && in_reset;
  endproperty
  a_pin_drive: assert property (p_pin_drive)
    else $error("reset pin not driven for supply reset");

  property p_pin_free;
    @(posedge clk_in) disable iff (!rstn_in)
    (state_r == rbvc_pkg::RBVC_RUN) |-> !ext_reset_pin_oe_out;
  endproperty
  a_pin_free: assert property (p_pin_free)
    else $error("reset pin driven after exit");

  property p_boot_vec;
    @(posedge clk_in) disable iff (!rstn_in)
    (in_reset && boot_sig_in == `RBVC_BOOT_SIG_VALUE)
      |=> start_addr_out == BOOT_VECTOR;
  endproperty
  a_boot_vec: assert property (p_boot_vec)
    else $error("bootloader vector not selected");

  property p_zero_vec;
    @(posedge clk_in) disable iff (!rstn_in)
    (in_reset && boot_sig_in != `RBVC_BOOT_SIG_VALUE)
      |=> start_addr_out == `RBVC_RESET_VECTOR;
  endproperty
  a_zero_vec: assert property (p_zero_vec)
    else $error("reset vector not zero");

  property p_ports;
    @(posedge clk_in) disable iff (!rstn_in)
    in_reset |-> port_od_out && port_latch_out && irq_tmr_disable_out;
  endproperty
  a_ports: assert property (p_ports)
    else $error("ports or interrupts not forced in reset");

  property p_run_cfg;
    @(posedge clk_in) disable iff (!rstn_in)
    $fell(core_halt_out) |-> wdt_enable_out && weak_pullup_en_out
      && clk_sel_out == `RBVC_CLK_SEL_INT;
  endproperty
  a_run_cfg: assert property (p_run_cfg)
    else $error("wrong configuration at reset exit");

  property p_por_cause;
    @(posedge clk_in) disable iff (!rstn_in)
    por_req_in |=> por_reset_out;
  endproperty
  a_por_cause: assert property (p_por_cause)
    else $error("power-on reset not flagged");

  property p_por_keep;
    @(posedge clk_in) disable iff (!rstn_in)
    (!in_reset && any_req && !por_req_in) |=> !por_reset_out;
  endproperty
  a_por_keep: assert property (p_por_keep)
    else $error("power-on-only bits reset by other source");

  property p_irq_off;
    @(posedge clk_in) disable iff (!rstn_in)
    any_req |=> irq_tmr_disable_out && sys_reset_out;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupts or timers left on in reset");

  property p_ram_keep;
    @(posedge clk_in) disable iff (!rstn_in)
    in_reset |-> ram_we_block_out;
  endproperty
  a_ram_keep: assert property (p_ram_keep)
    else $error("RAM writes open during reset");

  property p_pc_clear;
    @(posedge clk_in) disable iff (!rstn_in)
    $fell(core_halt_out) |-> $past(pc_clear_out);
  endproperty
  a_pc_clear: assert property (p_pc_clear)
    else $error("program counter not cleared before run");

  property p_pullup;
    @(posedge clk_in) disable iff (!rstn_in)
    weak_pullup_en_out;
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("weak pull-ups disabled");

  property p_start_hold;
    @(posedge clk_in) disable iff (!rstn_in)
    !in_reset |=> $stable(start_addr_out);
  endproperty
  a_start_hold: assert property (p_start_hold)
    else $error("start address changed outside reset");

  property p_release_go;
    @(posedge clk_in) disable iff (!rstn_in)
    (in_reset && hold_r == '0 && !any_req) |=> !in_reset;
  endproperty
  a_release_go: assert property (p_release_go)
    else $error("reset held after all requests cleared");

  property p_cause_keep;
    @(posedge clk_in) disable iff (!rstn_in)
    any_req |=> (cause_out & $past(req)) == $past(req);
  endproperty
  a_cause_keep: assert property (p_cause_keep)
    else $error("reset request missing from causes");

  property p_pin_in_reset;
    @(posedge clk_in) disable iff (!rstn_in)
    ext_reset_pin_oe_out |-> in_reset;
  endproperty
  a_pin_in_reset: assert property (p_pin_in_reset)
    else $error("reset pin driven outside reset");

endmodule

// ==== bench/rbvc_req_model.sv ====
`timescale 1ns/100ps
// ==========================================================
// Reset requesters and the reset pin
module rbvc_req_model (
  input wire logic [8:0] cmd_in, // Requests asked by the bench
  input wire logic pin_oe_in, // Device drives the pin
  input wire logic pin_drv_in, // Device pin value
  output logic [8:0] req_out, // Request levels
  output logic pin_lvl_out // Resolved pin level
);
  // Pin has a pull-up: low only when a party pulls it low
  assign pin_lvl_out = (pin_oe_in && !pin_drv_in) ? 1'b0 : !cmd_in[1];
  // Other requesters drive plain levels
  assign req_out = cmd_in;
endmodule

// ==== bench/reset_boot_vector_control_bench.sv ====
`timescale 1ns/100ps
// ==========================================================
// Bench top
module reset_boot_vector_control_bench;
  localparam logic [15:0] BV = 16'h1234;
  logic clk_in, rstn_in, pin, halt, sysr, latch, od, pu, irqd, ramb;
  logic pdrv, poe, pcc, wdt, bp, porr;
  logic [8:0] cmd, req, cause, expc;
  logic [15:0] sa;
  logic [1:0] cs;
  logic [7:0] sig;
  int error_cnt, num_checks, n, s, h, e, pe;
  // Device and its requesters
  rbvc_reset_ctrl #(.BOOT_VECTOR(BV)) i_rbvc_reset_ctrl (
    .clk_in(clk_in), .rstn_in(rstn_in), .por_req_in(req[0]),
    .ext_reset_pin_n_in(pin), .cmp_req_in(req[2]), .sw_req_in(req[3]),
    .vmon_req_in(req[4]), .wdt_req_in(req[5]), .mcd_req_in(req[6]),
    .flash_err_req_in(req[7]), .usb_req_in(req[8]), .boot_sig_in(sig),
    .core_halt_out(halt), .sys_reset_out(sysr), .por_reset_out(porr),
    .cause_out(cause), .port_latch_out(latch), .port_od_out(od),
    .weak_pullup_en_out(pu), .irq_tmr_disable_out(irqd),
    .ram_we_block_out(ramb), .ext_reset_pin_n_out(pdrv),
    .ext_reset_pin_oe_out(poe), .pc_clear_out(pcc), .start_addr_out(sa),
    .clk_sel_out(cs), .wdt_enable_out(wdt), .boot_present_out(bp));
  rbvc_req_model i_rbvc_req_model (.cmd_in(cmd), .pin_oe_in(poe),
    .pin_drv_in(pdrv), .req_out(req), .pin_lvl_out(pin));
  // Compare and count
  task automatic chk(input string nm, input logic [15:0] ex, got);
    num_checks++;
    if (got !== ex)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, ex, got);
    end
  endtask
  // First fetch address expected for a signature byte
  function automatic logic [15:0] exp_sa(input logic [7:0] b);
    return (b == 8'hA5) ? BV : 16'h0000;
  endfunction
  task automatic final_report;
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Count edges until the core runs, bounded
  task automatic wait_run;
    n = 0;
    while (n < 20 && halt !== 1'b0)
    begin
      @(posedge clk_in);
      n++;
      #1;
    end
    if (halt !== 1'b0)
    begin
      chk("halt_timeout", 16'h0, 16'h1);
      final_report();
    end
  endtask
  // Clock
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // Stimulus
  initial
  begin
    rstn_in = 1'b0;
    cmd = 9'h000;
    sig = 8'hA5;
    error_cnt = 0;
    num_checks = 0;
    void'($urandom(79));
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    chk("halt_por", 16'h1, {15'h0, halt});
    chk("pin_oe_por", 16'h1, {15'h0, poe});
    rstn_in = 1'b1;
    wait_run();
    chk("start_por", exp_sa(sig), sa);
    for (int i = 0; i < 24; i++)
    begin
      s = (i < 9) ? i : $urandom_range(8, 0);
      e = $urandom_range(8, 1);
      h = $urandom_range(3, 0);
      // Pin pulled while the device drives it is not a new request
      if ((s == 0 || s == 4) && e == 1)
        e = 2;
      expc = (9'h001 << s) | ((h > 0) ? (9'h001 << e) : 9'h000);
      pe = (s == 0 || s == 4 || (h > 0 && e == 4));
      @(negedge clk_in);
      sig = (i == 9) ? 8'hA4 : (i % 3 == 0) ? 8'hA5 : 8'($urandom);
      cmd = 9'h001 << s;
      @(negedge clk_in);
      cmd = (h > 0) ? (9'h001 << e) : 9'h000;
      @(negedge clk_in);
      chk("halt", 16'h1, {15'h0, halt});
      chk("sys_reset", 16'h1, {15'h0, sysr});
      chk("latch_od", 16'h3, {14'h0, latch, od});
      chk("irq_tmr_off", 16'h1, {15'h0, irqd});
      chk("ram_block", 16'h1, {15'h0, ramb});
      chk("pullup_in", 16'h1, {15'h0, pu});
      chk("pin_oe", 16'(pe), {15'h0, poe});
      chk("pin_drv", 16'h0, {15'h0, pdrv});
      chk("pc_clear", 16'h1, {15'h0, pcc});
      chk("por_reset", {15'h0, s == 0}, {15'h0, porr});
      if (h > 0)
      begin
        repeat (h - 1) @(negedge clk_in);
        cmd = 9'h000;
      end
      wait_run();
      chk("release_cnt", (h > 0) ? 16'h4 : 16'h3, 16'(n));
      chk("cause", {7'h0, expc}, {7'h0, cause});
      chk("start", exp_sa(sig), sa);
      chk("boot_flag", {15'h0, sig == 8'hA5}, {15'h0, bp});
      chk("clk_sel", 16'h0, {14'h0, cs});
      chk("wdt_on", 16'h1, {15'h0, wdt});
      chk("pullup_out", 16'h1, {15'h0, pu});
      chk("pin_oe_off", 16'h0, {15'h0, poe});
      chk("reset_off", 16'h0, {13'h0, sysr, irqd, porr});
      chk("od_off", 16'h0, {15'h0, od});
      chk("core_free", 16'h0, {14'h0, pcc, ramb});
    end
    // Mid-run power-on reset, then boot with no signature
    @(negedge clk_in);
    rstn_in = 1'b0;
    sig = 8'h5A;
    @(negedge clk_in);
    chk("cause_rst", 16'h0, {7'h0, cause});
    chk("pin_oe_rst", 16'h1, {15'h0, poe});
    chk("halt_rst", 16'h1, {15'h0, halt});
    rstn_in = 1'b1;
    wait_run();
    chk("release_rst", 16'h4, 16'(n));
    chk("start_rst", exp_sa(sig), sa);
    final_report();
  end
endmodule
